// ==== rtl/dcd_bank_timer.sv ====
// One bank's open flag and autoprecharge blocking counter.
`timescale 1ns/100ps
module dcd_bank_timer
    import dcd_pkg::*;
#(
    parameter int CNT_W = BLK_W
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    input  wire logic             ce_i,
    input  wire logic             open_i,
    input  wire logic             close_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_val_i,
    output logic                  open_o,
    output logic                  busy_o
);

    logic             open_q;
    logic [CNT_W-1:0] cnt;
    logic             next_open;
    logic [CNT_W-1:0] next_cnt;

    always_comb
    begin
        next_open = open_q;
        next_cnt  = cnt;
        if (cnt != '0)
        begin
            next_cnt = cnt - 1'b1;
        end
        if (close_i)
        begin
            next_open = 1'b0;
        end
        else if (open_i)
        begin
            next_open = 1'b1;
        end
        // Autoprecharge closes the row at issue; the counter then blocks it.
        if (load_i)
        begin
            next_open = 1'b0;
            next_cnt  = load_val_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            open_q <= 1'b0;
            cnt    <= '0;
        end
        else if (ce_i)
        begin
            open_q <= next_open;
            cnt    <= next_cnt;
        end
    end

    assign open_o = open_q;
    assign busy_o = (cnt != '0);

    chk_ap_block_len : assert property (@(posedge sys_clk_i)
        disable iff (srst_i || !ce_i)
        load_i && load_val_i != '0 |=> busy_o && !open_o)
        else $error("Autoprecharge block did not start.");

endmodule

// ==== rtl/dcd_core.sv ====
// Command decoder and clock-enable power-state logic for a four-bank DDR part.
// How it works
// - Clock enable sampled each edge and compared with previous sample.
// - Action uses the command decoded from the pins at the edge plus state held before the edge.
// - Enable falling, all banks idle, deselect or nop: precharge power-down.
// - Enable falling, some bank open, deselect or nop: active power-down.
// - Auto refresh with enable falling and banks idle: self refresh.
// - Commands decode from chip select, RAS, CAS, WE; A10 is autoprecharge.
// - Write-mask inputs never affect command decoding.
// - Mode register operand comes from A0 to A12 and both bank bits.
// - Write recovery time is honoured before the internal precharge.
// - Precharge with A10 high closes all banks, else the addressed one.
// - Power-down holds while enable low and exits when enable high.
`timescale 1ns/100ps
module dcd_core
    import dcd_pkg::*;
#(
    parameter int NBANK = NUM_BANKS
)
(
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic       ce_i,
    input  wire dcd_pins_s  pins_i,
    output dcd_cmd_s        cmd_o,
    output logic            cmd_valid_o,
    output dcd_state_e      state_o,
    output logic [NBANK-1:0] bank_open_o,
    output logic [NBANK-1:0] bank_busy_o,
    output logic [MODE_W-1:0] mode_reg_o,
    output logic [MODE_W-1:0] ext_mode_reg_o,
    output logic            illegal_o,
    output logic            read_ready_o
);

    dcd_state_e        state;
    dcd_state_e        next_state;
    logic              cke_prev;
    dcd_cmd_s          dec;
    dcd_cmd_s          cmd_q;
    dcd_cmd_s          next_cmd;
    logic              cmd_valid_q;
    logic              next_cmd_valid;
    logic              illegal_q;
    logic              next_illegal;
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] emode_q;
    logic [MODE_W-1:0] next_mode;
    logic [MODE_W-1:0] next_emode;
    logic [LOCK_W-1:0] lock_cnt;
    logic [LOCK_W-1:0] next_lock_cnt;
    logic              ready_q;
    logic              next_ready;
    logic              is_nop;
    logic              any_open;
    logic              normal;
    logic [NBANK-1:0]  b_open;
    logic [NBANK-1:0]  b_busy;
    logic [NBANK-1:0]  open_req;
    logic [NBANK-1:0]  close_req;
    logic [NBANK-1:0]  load_req;
    logic [BLK_W-1:0]  load_val;
    logic [NBANK-1:0]  open_q;
    logic [NBANK-1:0]  busy_q;

    // Strobe decode ignores the mask pin entirely.
    always_comb
    begin
        dec.cmd      = CMD_NONE;
        dec.auto_pre = pins_i.addr[AP_BIT];
        dec.ba       = pins_i.ba;
        dec.operand  = {pins_i.ba, pins_i.addr};
        is_nop       = 1'b1;
        if (!pins_i.cs_n)
        begin
            is_nop = 1'b0;
            case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
                CODE_MRS: dec.cmd = (pins_i.ba[0]) ? CMD_EMRS : CMD_MRS;
                CODE_REF: dec.cmd = CMD_REF;
                CODE_PRE: dec.cmd = (pins_i.addr[AP_BIT]) ? CMD_PREA
                                                          : CMD_PRE;
                CODE_ACT: dec.cmd = CMD_ACT;
                CODE_WR:  dec.cmd = CMD_WR;
                CODE_RD:  dec.cmd = CMD_RD;
                CODE_BST: dec.cmd = CMD_BST;
                CODE_NOP: is_nop  = 1'b1;
                default:  dec.cmd = CMD_NONE;
            endcase
        end
    end

    assign any_open = |open_q;
    // Normal decode only when enable was and is high and not powered down.
    assign normal = cke_prev && pins_i.cke && (state == ST_IDLE);

    // Power state; decided from the state before this edge.
    always_comb
    begin
        next_state   = state;
        next_illegal = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (cke_prev && !pins_i.cke)
                begin
                    if (is_nop && !any_open)
                        next_state = ST_PPD;
                    else if (is_nop)
                        next_state = ST_APD;
                    else if (dec.cmd == CMD_REF && !any_open)
                        next_state = ST_SREF;
                    else
                        next_illegal = 1'b1;
                end
                else if (!cke_prev && !pins_i.cke)
                begin
                    next_illegal = 1'b1;
                end
            end
            ST_PPD, ST_APD:
            begin
                if (pins_i.cke)
                begin
                    next_state = ST_IDLE;
                    next_illegal = !is_nop;
                end
            end
            ST_SREF:
            begin
                if (pins_i.cke)
                begin
                    next_state = ST_IDLE;
                    next_illegal = !is_nop;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Bank tracking and autoprecharge windows.
    always_comb
    begin
        open_req  = '0;
        close_req = '0;
        load_req  = '0;
        load_val  = BLK_W'(RD_AP_CYC);
        if (normal)
        begin
            case (dec.cmd)
                CMD_ACT: open_req[dec.ba] = 1'b1;
                CMD_PRE: close_req[dec.ba] = 1'b1;
                CMD_PREA: close_req = '1;
                CMD_RD:
                begin
                    load_req[dec.ba] = dec.auto_pre;
                end
                CMD_WR:
                begin
                    load_req[dec.ba] = dec.auto_pre;
                    load_val = BLK_W'(WR_AP_CYC);
                end
                default: load_req = '0;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < NBANK; g++)
        begin : g_bank
            dcd_bank_timer #(
                .CNT_W (BLK_W)
            ) u_bank (
                .sys_clk_i  (sys_clk_i),
                .srst_i     (srst_i),
                .ce_i       (ce_i),
                .open_i     (open_req[g]),
                .close_i    (close_req[g]),
                .load_i     (load_req[g]),
                .load_val_i (load_val),
                .open_o     (open_q[g]),
                .busy_o     (busy_q[g])
            );
        end
    endgenerate

    // Command output, mode registers, read lock-out after self refresh.
    always_comb
    begin
        next_cmd       = dec;
        next_cmd_valid = normal && (dec.cmd != CMD_NONE);
        next_mode      = mode_q;
        next_emode     = emode_q;
        next_lock_cnt  = lock_cnt;
        if (lock_cnt != '0)
            next_lock_cnt = lock_cnt - 1'b1;
        if (state == ST_SREF && pins_i.cke)
            next_lock_cnt = LOCK_W'(DLL_LOCK_CYC);
        if (normal && dec.cmd == CMD_MRS && !any_open)
            next_mode = dec.operand;
        if (normal && dec.cmd == CMD_EMRS && !any_open)
            next_emode = dec.operand;
        // Ready is registered so the output leaves a flop, in step with the count.
        next_ready     = (next_lock_cnt == '0);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state       <= ST_IDLE;
            cke_prev    <= 1'b0;
            cmd_q       <= '0;
            cmd_valid_q <= 1'b0;
            illegal_q   <= 1'b0;
            mode_q      <= '0;
            emode_q     <= '0;
            lock_cnt    <= '0;
            ready_q     <= 1'b1;
            b_open      <= '0;
            b_busy      <= '0;
        end
        else if (ce_i)
        begin
            state       <= next_state;
            cke_prev    <= pins_i.cke;
            cmd_q       <= next_cmd;
            cmd_valid_q <= next_cmd_valid;
            illegal_q   <= next_illegal;
            mode_q      <= next_mode;
            emode_q     <= next_emode;
            lock_cnt    <= next_lock_cnt;
            ready_q     <= next_ready;
            b_open      <= open_q;
            b_busy      <= busy_q;
        end
    end

    assign cmd_o          = cmd_q;
    assign cmd_valid_o    = cmd_valid_q;
    assign state_o        = state;
    assign bank_open_o    = b_open;
    assign bank_busy_o    = b_busy;
    assign mode_reg_o     = mode_q;
    assign ext_mode_reg_o = emode_q;
    assign illegal_o      = illegal_q;
    assign read_ready_o   = ready_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    chk_ppd_entry : assert property (
        state == ST_IDLE && cke_prev && !pins_i.cke && is_nop && !any_open
        |=> state == ST_PPD)
        else $error("Precharge power-down not entered.");
    chk_apd_entry : assert property (
        state == ST_IDLE && cke_prev && !pins_i.cke && is_nop && any_open
        |=> state == ST_APD)
        else $error("Active power-down not entered.");
    chk_sref_entry : assert property (
        state == ST_IDLE && cke_prev && !pins_i.cke &&
        dec.cmd == CMD_REF && !any_open |=> state == ST_SREF)
        else $error("Self refresh not entered.");
    chk_pd_hold : assert property (
        (state == ST_PPD || state == ST_APD) && !pins_i.cke
        |=> $stable(state))
        else $error("Power-down left while enable low.");
    chk_pd_exit : assert property (
        state != ST_IDLE && pins_i.cke |=> state == ST_IDLE)
        else $error("Low-power state not exited.");
    chk_cke_prev : assert property (
        pins_i.cke ##1 1'b1 |-> cke_prev)
        else $error("Previous enable sample lost.");
    chk_prea_all : assert property (
        normal && dec.cmd == CMD_PREA |=> open_q == '0)
        else $error("Precharge all left a bank open.");
    chk_act_open : assert property (
        normal && dec.cmd == CMD_ACT |=> open_q[$past(dec.ba)])
        else $error("Activate did not open bank.");
    chk_mrs_load : assert property (
        normal && dec.cmd == CMD_MRS && !any_open
        |=> mode_q == $past(dec.operand))
        else $error("Mode operand not captured.");
    // One check per bank, so the bank index cannot drift during the window.
    for (g = 0; g < NBANK; g++)
    begin : g_chk
        chk_rd_ap_len : assert property (@(posedge sys_clk_i)
            disable iff (srst_i || !ce_i)
            normal && dec.cmd == CMD_RD && dec.auto_pre &&
            dec.ba == BA_W'(g) |=> busy_q[g] [*5] ##1 !busy_q[g])
            else $error("Read autoprecharge window wrong.");
        chk_wr_ap_len : assert property (@(posedge sys_clk_i)
            disable iff (srst_i || !ce_i)
            normal && dec.cmd == CMD_WR && dec.auto_pre &&
            dec.ba == BA_W'(g) |=> busy_q[g] [*8] ##1 !busy_q[g])
            else $error("Write autoprecharge window wrong.");
    end
    chk_dll_lock : assert property (
        state == ST_SREF && pins_i.cke |=> !read_ready_o [*8])
        else $error("Read lock-out not started.");

    cov_ppd : cover property (state == ST_IDLE ##1 state == ST_PPD);
    cov_apd : cover property (state == ST_IDLE ##1 state == ST_APD);
    cov_sref : cover property (state == ST_SREF ##1 state == ST_IDLE);
    cov_rd_ap : cover property (normal && dec.cmd == CMD_RD && dec.auto_pre);

endmodule

// ==== rtl/dcd_pkg.sv ====
// Package with command codes, state encodings and timing counts for the decoder.
package dcd_pkg;

    localparam int NUM_BANKS   = 4;
    localparam int ADDR_W      = 13;
    localparam int BA_W        = 2;
    localparam int AP_BIT      = 10;
    localparam int MODE_W      = ADDR_W + BA_W;

    // Burst length and bank timings in clock cycles.
    localparam int BURST_LEN   = 4;
    localparam int T_RP_CYC    = 3;
    localparam int T_WR_CYC    = 2;
    localparam int RD_AP_CYC   = BURST_LEN / 2 + T_RP_CYC;
    localparam int WR_AP_CYC   = BURST_LEN / 2 + 1 + T_WR_CYC + T_RP_CYC;
    localparam int BLK_W       = 4;

    // Self-refresh exit interval and read lock-out after exit.
    localparam int T_XSR_NS    = 200;
    localparam int CLK_NS      = 5;
    localparam int XSR_CYC     = (T_XSR_NS + CLK_NS - 1) / CLK_NS;
    localparam int DLL_LOCK_CYC = 200;
    localparam int LOCK_W      = 8;

    // Encoded command strobes {ras_n, cas_n, we_n}.
    localparam logic [2:0] CODE_MRS  = 3'h0;
    localparam logic [2:0] CODE_REF  = 3'h1;
    localparam logic [2:0] CODE_PRE  = 3'h2;
    localparam logic [2:0] CODE_ACT  = 3'h3;
    localparam logic [2:0] CODE_WR   = 3'h4;
    localparam logic [2:0] CODE_RD   = 3'h5;
    localparam logic [2:0] CODE_BST  = 3'h6;
    localparam logic [2:0] CODE_NOP  = 3'h7;

    typedef enum logic [3:0] {
        CMD_NONE  = 4'h0,
        CMD_MRS   = 4'h1,
        CMD_EMRS  = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_RD    = 4'h4,
        CMD_WR    = 4'h5,
        CMD_PRE   = 4'h6,
        CMD_PREA  = 4'h7,
        CMD_BST   = 4'h8,
        CMD_REF   = 4'h9
    } dcd_cmd_e;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_PPD     = 4'h2,
        ST_APD     = 4'h4,
        ST_SREF    = 4'h8
    } dcd_state_e;

    // Pins sampled from the controller on each rising edge.
    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [BA_W-1:0]   ba;
        logic              dm;
    } dcd_pins_s;

    // Decoded command as the core reports it.
    typedef struct packed {
        dcd_cmd_e          cmd;
        logic              auto_pre;
        logic [BA_W-1:0]   ba;
        logic [MODE_W-1:0] operand;
    } dcd_cmd_s;

endpackage

// ==== tb/dcd_ctrl_model.sv ====
// Behavioural memory-controller model that drives the decoder's pins.
`timescale 1ns/100ps
module dcd_ctrl_model
    import dcd_pkg::*;
(
    input  wire logic sys_clk_i,
    output dcd_pins_s pins_o
);
    int seed = 32'h829590a9;

    initial
    begin
        pins_o = '0;
        pins_o.cs_n = 1'b1;
        pins_o.cke  = 1'b1;
    end

    // Pins change just after the edge so the decoder never samples a race.
    task automatic drive(input dcd_pins_s p);
        @(posedge sys_clk_i);
        #1;
        pins_o = p;
    endtask

    // Idle is deselect with scrambled strobes or a nop, never a command.
    task automatic idle(input logic cke);
        dcd_pins_s   p;
        logic [31:0] r;
        r = $random(seed);
        p = r[$bits(dcd_pins_s)-1:0];
        p.cke = cke;
        if (!p.cs_n)
        begin
            {p.ras_n, p.cas_n, p.we_n} = CODE_NOP;
        end
        drive(p);
    endtask
endmodule

// ==== tb/ddr_command_decode_cke_test.sv ====
// Self-checking testbench for the command decoder and power-state logic.
`timescale 1ns/100ps
module ddr_command_decode_cke_test
    import dcd_pkg::*;
;
    logic                  sys_clk_i = 1'b0;
    logic                  srst_i    = 1'b1;
    logic                  ce_i      = 1'b1;
    dcd_pins_s             pins;
    wire dcd_cmd_s         cmd_o;
    wire logic             cmd_valid_o;
    wire dcd_state_e       state_o;
    wire logic [3:0]       bank_open_o;
    wire logic [3:0]       bank_busy_o;
    wire logic [MODE_W-1:0] mode_reg_o;
    wire logic [MODE_W-1:0] ext_mode_reg_o;
    wire logic             illegal_o;
    wire logic             read_ready_o;
    int                    failures = 0;
    int                    checks = 0;
    int                    seed = 32'h829590a9;
    int                    lowcnt = 0;
    logic [NUM_BANKS-1:0]  exp_open = '0;
    logic [MODE_W-1:0]     exp_mode = '0;
    logic [MODE_W-1:0]     exp_ext = '0;
    logic [2:0]            codes [6] = '{CODE_ACT, CODE_RD, CODE_WR,
                                         CODE_BST, CODE_PRE, CODE_MRS};

    dcd_core dcd_core_i (
        .sys_clk_i      (sys_clk_i),
        .srst_i         (srst_i),
        .ce_i           (ce_i),
        .pins_i         (pins),
        .cmd_o          (cmd_o),
        .cmd_valid_o    (cmd_valid_o),
        .state_o        (state_o),
        .bank_open_o    (bank_open_o),
        .bank_busy_o    (bank_busy_o),
        .mode_reg_o     (mode_reg_o),
        .ext_mode_reg_o (ext_mode_reg_o),
        .illegal_o      (illegal_o),
        .read_ready_o   (read_ready_o)
    );

    dcd_ctrl_model dcd_ctrl_model_i (
        .sys_clk_i (sys_clk_i),
        .pins_o    (pins)
    );

    always #2.5 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i)
    begin
        if (read_ready_o === 1'b0)
        begin
            lowcnt <= lowcnt + 1;
        end
    end

    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic dcd_pins_s mk(input logic cke, input logic [2:0] code,
        input logic [ADDR_W-1:0] a, input logic [BA_W-1:0] b);
        dcd_pins_s p;
        p.cke = cke;
        p.cs_n = 1'b0;
        {p.ras_n, p.cas_n, p.we_n} = code;
        p.addr = a;
        p.ba = b;
        p.dm = 1'($random(seed));
        return p;
    endfunction

    function automatic logic [ADDR_W-1:0] rnd_addr(input logic ap);
        logic [ADDR_W-1:0] a;
        a = ADDR_W'($random(seed));
        a[AP_BIT] = ap;
        return a;
    endfunction

    function automatic dcd_cmd_e exp_cmd(input dcd_pins_s p);
        if (p.cs_n)
            return CMD_NONE;
        case ({p.ras_n, p.cas_n, p.we_n})
            CODE_MRS: return p.ba[0] ? CMD_EMRS : CMD_MRS;
            CODE_REF: return CMD_REF;
            CODE_PRE: return p.addr[AP_BIT] ? CMD_PREA : CMD_PRE;
            CODE_ACT: return CMD_ACT;
            CODE_WR:  return CMD_WR;
            CODE_RD:  return CMD_RD;
            CODE_BST: return CMD_BST;
            default:  return CMD_NONE;
        endcase
    endfunction

    // Two idle cycles after each command also cover tRP before a mode set.
    task automatic issue(input logic [2:0] code, input logic [ADDR_W-1:0] a,
        input logic [BA_W-1:0] b);
        dcd_pins_s p;
        dcd_cmd_e  e;
        logic      refused;
        p = mk(1'b1, code, a, b);
        e = exp_cmd(p);
        refused = (e == CMD_MRS || e == CMD_EMRS) && exp_open != '0;
        dcd_ctrl_model_i.drive(p);
        dcd_ctrl_model_i.idle(1'b1);
        if (!refused)
        begin
            compare(cmd_valid_o, e != CMD_NONE);
            compare(illegal_o, 1'b0);
            if (e != CMD_NONE)
            begin
                compare(cmd_o.cmd, e);
                compare(cmd_o.operand, {b, a});
                compare(cmd_o.ba, b);
            end
            if (e == CMD_RD || e == CMD_WR)
                compare(cmd_o.auto_pre, a[AP_BIT]);
        end
        case (e)
            CMD_ACT:  exp_open[b] = 1'b1;
            CMD_PRE:  exp_open[b] = 1'b0;
            CMD_PREA: exp_open = '0;
            CMD_MRS:  if (!refused) exp_mode = {b, a};
            CMD_EMRS: if (!refused) exp_ext = {b, a};
            default:  ;
        endcase
        dcd_ctrl_model_i.idle(1'b1);
        compare(bank_open_o, exp_open);
        compare(mode_reg_o, exp_mode);
        compare(ext_mode_reg_o, exp_ext);
    endtask

    // The autoprecharge window keeps the bank busy for cyc cycles and leaves it closed.
    task automatic ap(input logic [2:0] code, input logic [BA_W-1:0] b,
        input int cyc);
        int n;
        n = 0;
        dcd_ctrl_model_i.drive(mk(1'b1, code, rnd_addr(1'b1), b));
        repeat (16)
        begin
            dcd_ctrl_model_i.idle(1'b1);
            if (bank_busy_o[b] === 1'b1)
                n++;
        end
        compare(n, cyc);
        compare(bank_open_o[b], 1'b0);
        exp_open[b] = 1'b0;
    endtask

    task automatic pwr(input logic [2:0] code, input dcd_state_e st);
        int base;
        dcd_ctrl_model_i.drive(mk(1'b0, code, rnd_addr(1'b0), 2'h0));
        dcd_ctrl_model_i.idle(1'b0);
        compare(state_o, st);
        repeat (3) dcd_ctrl_model_i.idle(1'b0);
        compare(state_o, st);
        dcd_ctrl_model_i.idle(1'b1);
        base = lowcnt;
        dcd_ctrl_model_i.idle(1'b1);
        compare(state_o, ST_IDLE);
        if (st == ST_SREF)
        begin
            repeat (DLL_LOCK_CYC + 40) dcd_ctrl_model_i.idle(1'b1);
            compare(lowcnt - base, DLL_LOCK_CYC);
            compare(read_ready_o, 1'b1);
        end
    endtask

    initial
    begin
        #20000;
        failures++;
        summarize();
    end

    initial
    begin
        logic [2:0]      code;
        logic [BA_W-1:0] b;
        repeat (12) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
        compare(state_o, ST_IDLE);
        compare(read_ready_o, 1'b1);
        compare(bank_open_o, 4'h0);
        repeat (2) dcd_ctrl_model_i.idle(1'b1);
        issue(CODE_MRS, rnd_addr(1'b1), 2'h2);
        issue(CODE_MRS, rnd_addr(1'b0), 2'h1);
        issue(CODE_REF, rnd_addr(1'b0), 2'h0);
        issue(CODE_ACT, rnd_addr(1'b0), 2'h1);
        issue(CODE_WR, rnd_addr(1'b0), 2'h1);
        issue(CODE_RD, rnd_addr(1'b0), 2'h1);
        issue(CODE_BST, rnd_addr(1'b0), 2'h1);
        issue(CODE_MRS, rnd_addr(1'b0), 2'h0);
        issue(CODE_PRE, rnd_addr(1'b0), 2'h1);
        issue(CODE_ACT, rnd_addr(1'b0), 2'h0);
        issue(CODE_ACT, rnd_addr(1'b0), 2'h3);
        issue(CODE_PRE, rnd_addr(1'b1), 2'h2);
        issue(CODE_NOP, rnd_addr(1'b1), 2'h3);
        issue(CODE_ACT, rnd_addr(1'b0), 2'h2);
        ap(CODE_RD, 2'h2, RD_AP_CYC);
        issue(CODE_ACT, rnd_addr(1'b0), 2'h2);
        ap(CODE_WR, 2'h2, WR_AP_CYC);
        // Enable falling with an activate is not a legal entry.
        dcd_ctrl_model_i.drive(mk(1'b0, CODE_ACT, rnd_addr(1'b0), 2'h3));
        dcd_ctrl_model_i.idle(1'b1);
        compare(illegal_o, 1'b1);
        compare(state_o, ST_IDLE);
        pwr(CODE_NOP, ST_PPD);
        issue(CODE_ACT, rnd_addr(1'b0), 2'h1);
        pwr(CODE_NOP, ST_APD);
        issue(CODE_PRE, rnd_addr(1'b1), 2'h0);
        pwr(CODE_REF, ST_SREF);
        // A command held while the clock enable is low must wait for it.
        b = BA_W'($random(seed));
        dcd_ctrl_model_i.drive(mk(1'b1, CODE_ACT, rnd_addr(1'b0), b));
        ce_i = 1'b0;
        repeat (1 + $unsigned($random(seed)) % 4) @(posedge sys_clk_i);
        #1;
        compare(cmd_valid_o, 1'b0);
        compare(bank_open_o, exp_open);
        ce_i = 1'b1;
        dcd_ctrl_model_i.idle(1'b1);
        compare(cmd_valid_o, 1'b1);
        compare(cmd_o.cmd, CMD_ACT);
        exp_open[b] = 1'b1;
        dcd_ctrl_model_i.idle(1'b1);
        compare(bank_open_o, exp_open);
        repeat (60)
        begin
            code = codes[$unsigned($random(seed)) % 6];
            b = BA_W'($random(seed));
            if (code == CODE_ACT && exp_open[b])
                code = CODE_RD;
            else if ((code == CODE_RD || code == CODE_WR) && !exp_open[b])
                code = CODE_ACT;
            else if (code == CODE_MRS && exp_open != '0)
                code = CODE_PRE;
            issue(code, rnd_addr(code == CODE_PRE && b[0]), b);
        end
        summarize();
    end
endmodule
